// ===== rtl/dpb_port_host.sv
// port controller: apb registers in, one ram port's pins out
`timescale 1ns/1ps
module dpb_port_host
  import dpb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // ram port
  dpb_port_if.host port
);
  typedef enum logic [1:0] {H_IDLE, H_GAP, H_RUN, H_DRAIN} dpb_hstate_t;
  dpb_hstate_t st_q, st_d;
  logic [7:0] cfg_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdat_q, rdat_q, hdq_q;
  logic [1:0] op_q, beat_q, beat_d, gap_q, gap_d, tap_q, cap_q;
  logic done_q, pready_q, pslverr_q, rd_act_q;
  logic cs_n_q, dir_q, ads_n_q, cen_n_q, clr_n_q, oe_n_q, hoe_n_q;
  logic [3:0] bytes_n_q;
  logic [31:0] prdata_q, rd_d;
  logic err_d;

  // ****************************************
  // register bus decode
  // ****************************************
  logic take, done_acc, wr_en, idle, go, cfg_wr, run_d, cap, done_set;
  logic [1:0] wsel, last_beat, lane_d, cap_lane;
  assign take = psel && penable && !pready_q;
  assign done_acc = psel && penable && pready_q;
  assign wr_en = done_acc && pwrite;
  assign idle = st_q == H_IDLE;
  assign go = wr_en && paddr == REG_CMD && idle;
  // width pins only move while idle
  assign cfg_wr = wr_en && paddr == REG_CFG && idle;
  assign wsel = wcode(cfg_q[CFG_BM], cfg_q[CFG_SIZE]);
  // beats per operation; readback holds the pattern 2 or 3 cycles
  assign last_beat = (op_q == OP_CLEAR) ? 2'h0 :
                     (op_q == OP_RDBK) ? ((wsel == W9) ? RB_LAST_X9 : RB_LAST) :
                     lane_last(wsel);
  assign run_d = st_d == H_RUN;
  assign lane_d = cfg_q[CFG_ORDER] ? lane_last(wsel) - beat_d : beat_d;
  assign cap_lane = cfg_q[CFG_ORDER] ? lane_last(wsel) - cap_q : cap_q;
  // data of a beat is on the wire one edge later, pipelined two
  assign cap = cfg_q[CFG_LAT] ? tap_q[1] : tap_q[0];
  assign done_set = st_q == H_DRAIN && st_d == H_IDLE;

  // register read mux; unmapped answers with an error
  always_comb begin
    rd_d = 32'h0;
    err_d = 1'b0;
    case (paddr)
      REG_CFG: rd_d = {24'h0, cfg_q};
      REG_ADDR: rd_d = 32'(addr_q);
      REG_WDLO: rd_d = wdat_q[31:0];
      REG_WDHI: rd_d = {28'h0, wdat_q[35:32]};
      REG_CMD: rd_d = {30'h0, op_q};
      REG_RDLO: rd_d = rdat_q[31:0];
      REG_RDHI: rd_d = {28'h0, rdat_q[35:32]};
      REG_STAT: rd_d = {30'h0, done_q, !idle};
      default: err_d = 1'b1;
    endcase
  end

  // ****************************************
  // sequencer
  // ****************************************
  // gap keeps config settled and the other port's write delay elapsed
  always_comb begin
    st_d = st_q;
    beat_d = beat_q;
    gap_d = gap_q;
    case (st_q)
      H_IDLE: if (go) begin
        st_d = H_GAP;
        gap_d = 2'(GAP_CYC - 1);
      end
      H_GAP: if (gap_q == 2'h0) begin
        st_d = H_RUN;
        beat_d = 2'h0;
      end else begin
        gap_d = gap_q - 2'h1;
      end
      H_RUN: if (beat_q == last_beat) st_d = H_DRAIN;
        else beat_d = beat_q + 2'h1;
      H_DRAIN: if (tap_q == 2'h0 && !rd_act_q) st_d = H_IDLE;
      default: st_d = H_IDLE;
    endcase
  end

  // registers, apb answer and capture
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= H_IDLE;
      beat_q <= 2'h0;
      gap_q <= 2'h0;
      cfg_q <= CFG_RESET;
      addr_q <= '0;
      wdat_q <= '0;
      rdat_q <= '0;
      op_q <= OP_READ;
      done_q <= 1'b0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
      tap_q <= 2'h0;
      cap_q <= 2'h0;
    end else begin
      st_q <= st_d;
      beat_q <= beat_d;
      gap_q <= gap_d;
      pready_q <= take;
      pslverr_q <= take && err_d;
      if (take && !pwrite) prdata_q <= rd_d;
      if (cfg_wr) cfg_q <= pwdata[7:0];
      if (wr_en && paddr == REG_ADDR) addr_q <= pwdata[ADDR_W-1:0];
      if (wr_en && paddr == REG_WDLO) wdat_q[31:0] <= pwdata;
      if (wr_en && paddr == REG_WDHI) wdat_q[35:32] <= pwdata[3:0];
      if (go) op_q <= pwdata[1:0];
      // a finishing operation wins over a clear in the same cycle
      done_q <= done_set || (done_q && !(wr_en && paddr == REG_STAT && pwdata[STAT_DONE]));
      tap_q <= {tap_q[0], rd_act_q};
      if (go) cap_q <= 2'h0;
      else if (cap) cap_q <= cap_q + 2'h1;
      if (cap && op_q == OP_RDBK) rdat_q <= {rdat_q[17:0], port.dq[17:0]};
      else if (cap) rdat_q <= (rdat_q & ~expand(lane_mask(wsel, cap_lane))) |
                              (spread(wsel, port.dq) & expand(lane_mask(wsel, cap_lane)));
    end
  end

  // ****************************************
  // pin drive, registered for the beat being entered
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cs_n_q <= 1'b1;
      dir_q <= 1'b1;
      ads_n_q <= 1'b1;
      cen_n_q <= 1'b1;
      clr_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      hoe_n_q <= 1'b1;
      hdq_q <= '0;
      rd_act_q <= 1'b0;
      bytes_n_q <= 4'hF;
    end else begin
      // deselected between operations, never a selected no-op
      cs_n_q <= !(run_d && op_q != OP_CLEAR);
      dir_q <= op_q != OP_WRITE;
      // strobe only the first lane; readback holds it low
      ads_n_q <= !(run_d && (op_q == OP_RDBK || beat_d == 2'h0));
      cen_n_q <= !(run_d && (op_q == OP_READ || op_q == OP_WRITE));
      clr_n_q <= !(run_d && op_q == OP_CLEAR);
      // device outputs held off while this port writes
      oe_n_q <= op_q == OP_WRITE;
      hoe_n_q <= !(run_d && op_q == OP_WRITE);
      hdq_q <= pick(wsel, lane_d, wdat_q);
      rd_act_q <= run_d && (op_q == OP_READ || op_q == OP_RDBK);
      bytes_n_q <= ~cfg_q[CFG_BYTE +: 4];
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign port.port_select_n = cs_n_q;
  assign port.dir_read_high = dir_q;
  assign port.output_drive_en_n = oe_n_q;
  assign port.addr_strobe_n = ads_n_q;
  assign port.count_enable_n = cen_n_q;
  assign port.counter_clear_n = clr_n_q;
  assign port.latency_select = cfg_q[CFG_LAT];
  assign port.width_match_sel = cfg_q[CFG_BM];
  assign port.size_sel = cfg_q[CFG_SIZE];
  assign port.lane_order_sel = cfg_q[CFG_ORDER];
  assign {port.byte_lane3_n, port.byte_lane2_n, port.byte_lane1_n, port.byte_lane0_n} = bytes_n_q;
  assign port.addr = addr_q;
  assign port.host_dq_o = hdq_q;
  assign port.host_dq_oe_n = hoe_n_q;
endmodule : dpb_port_host

// ===== rtl/dpb_pkg.sv
// shared constants, register map and lane decoding for the burst dual-port ram
package dpb_pkg;
  // ****************************************
  // geometry and width codes
  // ****************************************
  localparam int ADDR_W = 15;
  localparam int DATA_W = 36;
  localparam int LANE_W = 9;
  localparam int LANES = 4;
  localparam logic [1:0] W36 = 2'h0;
  localparam logic [1:0] W18 = 2'h1;
  localparam logic [1:0] W9 = 2'h2;
  // counter readback field positions
  localparam int RB36_POS = 3;
  localparam int RB18_POS = 2;
  localparam int RB9_POS = 1;
  localparam int RB9_SPLIT = 6;
  // last beat of a hold-and-read pattern, one less than the cycles it is held
  localparam logic [1:0] RB_LAST = 2'h1;
  localparam logic [1:0] RB_LAST_X9 = 2'h2;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int WR_RD_DELAY_NS = 30;
  localparam int SKEW_WINDOW_NS = 9;
  // least times round up
  localparam int WR_RD_CYC = (WR_RD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CFG_LEAD_CYC = 1;
  localparam int GAP_CYC = (WR_RD_CYC > CFG_LEAD_CYC) ? WR_RD_CYC : CFG_LEAD_CYC;
  // ****************************************
  // host register map
  // ****************************************
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDLO = 8'h08;
  localparam logic [7:0] REG_WDHI = 8'h0C;
  localparam logic [7:0] REG_CMD = 8'h10;
  localparam logic [7:0] REG_RDLO = 8'h14;
  localparam logic [7:0] REG_RDHI = 8'h18;
  localparam logic [7:0] REG_STAT = 8'h1C;
  localparam int CFG_LAT = 0;
  localparam int CFG_BM = 1;
  localparam int CFG_SIZE = 2;
  localparam int CFG_ORDER = 3;
  localparam int CFG_BYTE = 4;
  localparam logic [7:0] CFG_RESET = 8'hF0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_RDBK = 2'h2;
  localparam logic [1:0] OP_CLEAR = 2'h3;
  // ****************************************
  // lane decoding
  // ****************************************
  function automatic logic [1:0] wcode(input logic bm, input logic size);
    return !bm ? W36 : (size ? W9 : W18);
  endfunction : wcode
  function automatic logic [1:0] lane_last(input logic [1:0] w);
    return (w == W9) ? 2'h3 : ((w == W18) ? 2'h1 : 2'h0);
  endfunction : lane_last
  function automatic logic [3:0] lane_mask(input logic [1:0] w, input logic [1:0] idx);
    if (w == W9) return 4'h1 << idx;
    if (w == W18) return idx[0] ? 4'hC : 4'h3;
    return 4'hF;
  endfunction : lane_mask
  function automatic logic [35:0] spread(input logic [1:0] w, input logic [35:0] d);
    if (w == W9) return {4{d[8:0]}};
    if (w == W18) return {2{d[17:0]}};
    return d;
  endfunction : spread
  function automatic logic [35:0] pick(input logic [1:0] w, input logic [1:0] idx,
                                       input logic [35:0] d);
    if (w == W9) return {27'h0, d[idx*LANE_W +: LANE_W]};
    if (w == W18) return {18'h0, d[idx[0]*18 +: 18]};
    return d;
  endfunction : pick
  function automatic logic [35:0] expand(input logic [3:0] m);
    logic [35:0] r;
    for (int j = 0; j < LANES; j++) r[j*LANE_W +: LANE_W] = {LANE_W{m[j]}};
    return r;
  endfunction : expand
endpackage : dpb_pkg

// ===== rtl/dpb_port_if.sv
// pin bundle of one ram port with the shared data wire resolved from enables
`timescale 1ns/1ps
interface dpb_port_if;
  import dpb_pkg::*;
  logic port_select_n, dir_read_high, output_drive_en_n;
  logic addr_strobe_n, count_enable_n, counter_clear_n;
  logic latency_select, width_match_sel, size_sel, lane_order_sel;
  logic byte_lane0_n, byte_lane1_n, byte_lane2_n, byte_lane3_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] host_dq_o;
  logic host_dq_oe_n;
  logic [DATA_W-1:0] dev_dq_o;
  logic dev_dq_oe_n;
  logic [DATA_W-1:0] dq;
  logic dev_drive;
  // output enable gates the device drive without the clock
  assign dev_drive = !dev_dq_oe_n && !output_drive_en_n;
  // undriven wire reads as zero here
  assign dq = dev_drive ? dev_dq_o : (!host_dq_oe_n ? host_dq_o : '0);
  modport device (
    input port_select_n, dir_read_high, output_drive_en_n,
    input addr_strobe_n, count_enable_n, counter_clear_n,
    input latency_select, width_match_sel, size_sel, lane_order_sel,
    input byte_lane0_n, byte_lane1_n, byte_lane2_n, byte_lane3_n,
    input addr, dq,
    output dev_dq_o, dev_dq_oe_n
  );
  modport host (
    output port_select_n, dir_read_high, output_drive_en_n,
    output addr_strobe_n, count_enable_n, counter_clear_n,
    output latency_select, width_match_sel, size_sel, lane_order_sel,
    output byte_lane0_n, byte_lane1_n, byte_lane2_n, byte_lane3_n,
    output addr, host_dq_o, host_dq_oe_n,
    input dq
  );
endinterface : dpb_port_if

// ===== rtl/dpb_burst_ctr.sv
// burst address counter with lane sub-counter for one port
`timescale 1ns/1ps
module dpb_burst_ctr
  import dpb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // counter controls, sampled at the port clock
  input wire logic clear_n,
  input wire logic ads_n,
  input wire logic count_enable_n_n,
  input wire logic [1:0] wsel,
  input wire logic [ADDR_W-1:0] ext_addr,
  // next and present counter state
  output logic [ADDR_W-1:0] word_d,
  output logic [1:0] pos_d,
  output logic [ADDR_W-1:0] word_q,
  output logic [1:0] pos_q
);
  logic fresh_d;
  logic fresh_q;
  logic wrap;
  logic load_ok;

  // a word in flight finishes its lanes before a new address is taken
  assign wrap = pos_q == lane_last(wsel);
  assign load_ok = wrap || fresh_q;

  // clear beats load, load beats increment, else hold
  always_comb begin
    word_d = word_q;
    pos_d = pos_q;
    fresh_d = fresh_q;
    if (!clear_n) begin
      word_d = '0;
      pos_d = 2'h0;
      fresh_d = 1'b1;
    end else if (!count_enable_n_n && !ads_n && load_ok) begin
      word_d = ext_addr;
      pos_d = 2'h0;
      fresh_d = 1'b0;
    end else if (!count_enable_n_n) begin
      pos_d = wrap ? 2'h0 : pos_q + 2'h1;
      word_d = wrap ? word_q + ADDR_W'(1) : word_q;
      fresh_d = 1'b0;
    end else begin
      // a stopped burst frees the next strobe to load, so a width change
      // between bursts cannot leave a stale lane count blocking the load
      fresh_d = 1'b1;
    end
  end

  // counter state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      word_q <= '0;
      pos_q <= 2'h0;
      fresh_q <= 1'b1;
    end else begin
      word_q <= word_d;
      pos_q <= pos_d;
      fresh_q <= fresh_d;
    end
  end
endmodule : dpb_burst_ctr

// ===== rtl/dpb_sram_dev.sv
// two-port burst ram: storage, per-port access decode and output timing
`timescale 1ns/1ps
module dpb_sram_dev
  import dpb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // left port, 36 bits with byte lanes
  dpb_port_if.device left_port,
  // right port, with bus matching
  dpb_port_if.device right_port
);
  localparam int NP = 2;
  localparam int DEPTH = 2 ** ADDR_W;

  // ****************************************
  // pin views, index 0 left, 1 right
  // ****************************************
  logic [NP-1:0] cs_n;
  logic [NP-1:0] dir;
  logic [NP-1:0] clr_n;
  logic [NP-1:0] ads_n;
  logic [NP-1:0] cen_n;
  logic [NP-1:0] oe_n;
  logic [NP-1:0] lat;
  logic [NP-1:0] ord;
  logic [1:0] wsel [NP];
  logic [3:0] left_bytes_n;
  logic [ADDR_W-1:0] ext_a [NP];
  logic [DATA_W-1:0] din [NP];

  // port fan-in
  assign cs_n = {right_port.port_select_n, left_port.port_select_n};
  assign dir = {right_port.dir_read_high, left_port.dir_read_high};
  assign clr_n = {right_port.counter_clear_n, left_port.counter_clear_n};
  assign ads_n = {right_port.addr_strobe_n, left_port.addr_strobe_n};
  assign cen_n = {right_port.count_enable_n, left_port.count_enable_n};
  assign oe_n = {right_port.output_drive_en_n, left_port.output_drive_en_n};
  assign lat = {right_port.latency_select, left_port.latency_select};
  // order only matters on a narrow right port
  assign ord = {right_port.lane_order_sel, 1'b0};
  assign ext_a[0] = left_port.addr;
  assign ext_a[1] = right_port.addr;
  assign din[0] = left_port.dq;
  assign din[1] = right_port.dq;
  assign left_bytes_n = {left_port.byte_lane3_n, left_port.byte_lane2_n,
                         left_port.byte_lane1_n, left_port.byte_lane0_n};
  // left is always full width; right decodes its width pins
  assign wsel[0] = W36;
  assign wsel[1] = wcode(right_port.width_match_sel, right_port.size_sel);

  // ****************************************
  // storage and per-port access
  // ****************************************
  logic [DATA_W-1:0] mem [DEPTH];
  logic [ADDR_W-1:0] acc_a [NP];
  logic [NP-1:0] wr;
  logic [3:0] wmask [NP];
  logic [DATA_W-1:0] wdata [NP];
  logic [DATA_W-1:0] out_q [NP];
  logic [NP-1:0] oen_q;

  for (genvar g = 0; g < NP; g++) begin : g_port
    logic [ADDR_W-1:0] word_d;
    logic [ADDR_W-1:0] word_q;
    logic [1:0] pos_d;
    logic [1:0] pos_q;
    logic [1:0] lane;
    logic [1:0] rb_d;
    logic [1:0] rb_q;
    logic hold_rd;
    logic rd_en;
    logic [DATA_W-1:0] rb_val;
    logic [DATA_W-1:0] fresh;
    logic [DATA_W-1:0] s1_q;
    logic s1_en_q;

    // counter is fed whatever the select pin says
    dpb_burst_ctr u_ctr (
      .clk(clk),
      .sys_rst(sys_rst),
      .clear_n(clr_n[g]),
      .ads_n(ads_n[g]),
      .count_enable_n_n(cen_n[g]),
      .wsel(wsel[g]),
      .ext_addr(ext_a[g]),
      .word_d(word_d),
      .pos_d(pos_d),
      .word_q(word_q),
      .pos_q(pos_q)
    );

    // access goes to the counter's next value, so a clear costs no cycle
    assign acc_a[g] = word_d;
    // big-endian order walks the lanes downward
    assign lane = ord[g] ? lane_last(wsel[g]) - pos_d : pos_d;

    // access decode from the pins seen at this edge
    assign hold_rd = !ads_n[g] && cen_n[g] && clr_n[g] && dir[g] && !oe_n[g];
    assign rd_en = !cs_n[g] && dir[g];
    assign wr[g] = !cs_n[g] && !dir[g];
    assign wmask[g] = (g == 0) ? ~left_bytes_n : lane_mask(wsel[g], lane);
    assign wdata[g] = spread(wsel[g], din[g]);

    // readback counts cycles of a held pattern; x9 sends high part first
    assign rb_d = !hold_rd ? 2'h0 : ((rb_q == 2'h3) ? rb_q : rb_q + 2'h1);
    assign rb_val = (wsel[g] == W9) ?
                    ((rb_q == 2'h0) ? DATA_W'(word_q[ADDR_W-1:RB9_SPLIT]) :
                     (DATA_W'({pos_q, word_q[RB9_SPLIT-1:0]}) << RB9_POS)) :
                    ((wsel[g] == W18) ? (DATA_W'({pos_q[0], word_q}) << RB18_POS) :
                     (DATA_W'(word_q) << RB36_POS));

    // a read of a word the other port writes at this same edge sees the
    // old word; the new one is there from the next edge on, which meets
    // the write-to-read delay from either side alike
    assign fresh = hold_rd ? rb_val : pick(wsel[g], lane, mem[acc_a[g]]);

    // flow-through takes fresh data, pipelined takes the extra stage
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        s1_q <= '0;
        s1_en_q <= 1'b0;
        out_q[g] <= '0;
        oen_q[g] <= 1'b1;
        rb_q <= 2'h0;
      end else begin
        s1_q <= fresh;
        s1_en_q <= rd_en;
        out_q[g] <= lat[g] ? s1_q : fresh;
        oen_q[g] <= lat[g] ? !s1_en_q : !rd_en;
        rb_q <= rb_d;
      end
    end
  end

  // ****************************************
  // write port of the array
  // ****************************************
  // one process for both ports; on a same-word clash the right port lands last
  always_ff @(posedge clk) begin
    for (int p = 0; p < NP; p++) begin
      for (int j = 0; j < LANES; j++) begin
        if (wr[p] && wmask[p][j]) begin
          mem[acc_a[p]][j*LANE_W +: LANE_W] <= wdata[p][j*LANE_W +: LANE_W];
        end
      end
    end
  end

  // ****************************************
  // pin drive
  // ****************************************
  assign left_port.dev_dq_o = out_q[0];
  assign left_port.dev_dq_oe_n = oen_q[0];
  assign right_port.dev_dq_o = out_q[1];
  assign right_port.dev_dq_oe_n = oen_q[1];
endmodule : dpb_sram_dev

// ===== test/dpb_chk.sv
// assertion checker on the left ram port pins
`timescale 1ns/1ps
module dpb_chk
  import dpb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // controls
  input wire logic port_select_n,
  input wire logic dir_read_high,
  input wire logic output_drive_en_n,
  input wire logic addr_strobe_n,
  input wire logic count_enable_n,
  input wire logic counter_clear_n,
  input wire logic latency_select,
  input wire logic [ADDR_W-1:0] addr,
  // data
  input wire logic [DATA_W-1:0] host_dq_o,
  input wire logic host_dq_oe_n,
  input wire logic [DATA_W-1:0] dev_dq_o,
  input wire logic dev_dq_oe_n,
  input wire logic [DATA_W-1:0] dq
);
  // shadow counter; left port is always x36, so no sub-counter to track
  logic [ADDR_W-1:0] ctr_q;
  logic [ADDR_W-1:0] ctr_d;
  assign ctr_d = !counter_clear_n ? '0 : (count_enable_n ? ctr_q :
                 (addr_strobe_n ? ctr_q + ADDR_W'(1) : addr));
  always_ff @(posedge clk) begin
    ctr_q <= sys_rst ? '0 : ctr_d;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // hold-and-read pattern
  sequence s_rb;
    !port_select_n && dir_read_high && !output_drive_en_n && !addr_strobe_n &&
      count_enable_n && counter_clear_n;
  endsequence
  sequence s_pipe_rb;
    s_rb ##0 latency_select ##1 latency_select;
  endsequence
  property p_desel_ft;
    port_select_n && !latency_select |=> dev_dq_oe_n;
  endproperty
  a_desel_ft: assert property (p_desel_ft) else $error("flow deselect drove");
  property p_desel_pipe;
    port_select_n && latency_select ##1 latency_select |=> dev_dq_oe_n;
  endproperty
  a_desel_pipe: assert property (p_desel_pipe) else $error("pipe deselect drove");
  property p_read_ft;
    !port_select_n && dir_read_high && !latency_select |=> !dev_dq_oe_n;
  endproperty
  a_read_ft: assert property (p_read_ft) else $error("flow read not driven");
  property p_read_pipe;
    !port_select_n && dir_read_high && latency_select ##1 latency_select |=> !dev_dq_oe_n;
  endproperty
  a_read_pipe: assert property (p_read_pipe) else $error("pipe read not driven");
  property p_write_ft;
    !port_select_n && !dir_read_high && !latency_select |=> dev_dq_oe_n;
  endproperty
  a_write_ft: assert property (p_write_ft) else $error("write cycle drove");
  property p_rb_ft;
    s_rb ##0 !latency_select |=> dev_dq_o == {18'h0, ctr_q, 3'h0};
  endproperty
  a_rb_ft: assert property (p_rb_ft) else $error("flow readback wrong");
  property p_rb_pipe;
    s_pipe_rb |=> dev_dq_o == {18'h0, $past(ctr_q), 3'h0};
  endproperty
  a_rb_pipe: assert property (p_rb_pipe) else $error("pipe readback wrong");
  property p_async;
    output_drive_en_n |-> dq == (host_dq_oe_n ? '0 : host_dq_o);
  endproperty
  a_async: assert property (p_async) else $error("disabled output still on wire");
endmodule : dpb_chk

// ===== test/tb.sv
// self-checking bench: two port controllers facing the burst ram
`timescale 1ns/1ps
module tb;
  import dpb_pkg::*;
  // one row: writer, reader, their configs, address, word
  typedef struct {int w; int r; logic [7:0] cw; logic [7:0] cr; logic [14:0] a;
    logic [35:0] d;} dpb_row_t;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] paddr [2] = '{8'h0, 8'h0};
  logic psel [2] = '{1'b0, 1'b0};
  logic penable [2] = '{1'b0, 1'b0};
  logic pwrite [2] = '{1'b0, 1'b0};
  logic [31:0] pwdata [2] = '{32'h0, 32'h0};
  logic [31:0] prdata [2];
  logic pready [2];
  logic pslverr [2];
  logic [31:0] rd;
  logic err;
  logic [35:0] q;
  logic [35:0] m;
  logic [35:0] mdl [int];
  int fails = 0;
  int cmp_count = 0;
  dpb_row_t rows [7];
  dpb_port_if pif [2] ();
  // ****************************************
  // clock and design
  // ****************************************
  initial forever #25 clk = ~clk;
  dpb_sram_dev dpb_sram_dev_inst (.clk(clk), .sys_rst(sys_rst), .left_port(pif[0].device),
    .right_port(pif[1].device));
  for (genvar h = 0; h < 2; h++) begin : g_host
    dpb_port_host dpb_port_host_inst (.clk(clk), .sys_rst(sys_rst), .paddr(paddr[h]),
      .psel(psel[h]), .penable(penable[h]), .pwrite(pwrite[h]), .pwdata(pwdata[h]),
      .prdata(prdata[h]), .pready(pready[h]), .pslverr(pslverr[h]), .port(pif[h].host));
  end
  dpb_chk dpb_chk_inst (.clk(clk), .sys_rst(sys_rst), .port_select_n(pif[0].port_select_n),
    .dir_read_high(pif[0].dir_read_high), .output_drive_en_n(pif[0].output_drive_en_n),
    .addr_strobe_n(pif[0].addr_strobe_n), .count_enable_n(pif[0].count_enable_n),
    .counter_clear_n(pif[0].counter_clear_n), .latency_select(pif[0].latency_select),
    .addr(pif[0].addr), .host_dq_o(pif[0].host_dq_o), .host_dq_oe_n(pif[0].host_dq_oe_n),
    .dev_dq_o(pif[0].dev_dq_o), .dev_dq_oe_n(pif[0].dev_dq_oe_n), .dq(pif[0].dq));
  // one apb transfer; waits for pready, no fixed latency assumed
  task apb(input int h, input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel[h] <= 1'b1;
    pwrite[h] <= wr;
    paddr[h] <= a;
    pwdata[h] <= wd;
    @(posedge clk);
    penable[h] <= 1'b1;
    do @(posedge clk); while (pready[h] !== 1'b1);
    rd = prdata[h];
    err = pslverr[h];
    psel[h] <= 1'b0;
    penable[h] <= 1'b0;
  endtask : apb
  // configure, run one port operation, fetch the captured word
  task acc(input int h, input logic [7:0] cfg, input logic [1:0] c, input logic [14:0] a,
           input logic [35:0] d);
    apb(h, 1'b1, REG_CFG, {24'h0, cfg});
    apb(h, 1'b1, REG_ADDR, {17'h0, a});
    apb(h, 1'b1, REG_WDLO, d[31:0]);
    apb(h, 1'b1, REG_WDHI, {28'h0, d[35:32]});
    apb(h, 1'b1, REG_CMD, {30'h0, c});
    do apb(h, 1'b0, REG_STAT, 32'h0); while (rd[STAT_DONE] !== 1'b1);
    apb(h, 1'b1, REG_STAT, 32'h2);
    apb(h, 1'b0, REG_RDLO, 32'h0);
    q[31:0] = rd;
    apb(h, 1'b0, REG_RDHI, 32'h0);
    q[35:32] = rd[3:0];
  endtask : acc
  task chk(input logic [35:0] got, input logic [35:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  initial begin
    rows = '{'{0, 1, 8'hF0, 8'hF0, 15'h0012, 36'h987654321},
             '{1, 0, 8'hF2, 8'hF1, 15'h7FFF, 36'hA5A5A5A5A},
             '{1, 0, 8'hFE, 8'hF0, 15'h0000, 36'h123456789},
             '{0, 1, 8'h50, 8'hF7, 15'h0012, 36'hFFFFFFFFF},
             '{1, 0, 8'hFB, 8'hF0, 15'h1234, 36'h3C3C30F0F},
             '{0, 1, 8'hF1, 8'hFA, 15'h4321, 36'h612345678},
             '{1, 1, 8'hF6, 8'hFF, 15'h0555, 36'h80F1E2D3C}};
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    // table rows: write on one port, read on either, mixed widths and orders
    foreach (rows[i]) begin
      for (int j = 0; j < 4; j++) m[j*9 +: 9] = {9{rows[i].w == 1 || rows[i].cw[4+j]}};
      acc(rows[i].w, rows[i].cw, OP_WRITE, rows[i].a, rows[i].d);
      mdl[rows[i].a] = (mdl[rows[i].a] & ~m) | (rows[i].d & m);
      acc(rows[i].r, rows[i].cr, OP_READ, rows[i].a, 36'h0);
      chk(q, mdl[rows[i].a]);
      $display("row %0d done", i);
    end
    // counter loaded by a read, shown, then cleared while deselected
    for (int l = 0; l < 2; l++) begin
      acc(0, {7'h78, l[0]}, OP_READ, 15'h2AB5, 36'h0);
      acc(0, {7'h78, l[0]}, OP_RDBK, 15'h0, 36'h0);
      chk(q, {2{15'h2AB5, 3'h0}});
      acc(0, {7'h78, l[0]}, OP_CLEAR, 15'h0, 36'h0);
      acc(0, {7'h78, l[0]}, OP_RDBK, 15'h0, 36'h0);
      chk(q, 36'h0);
      $display("counter test done, latency %0d", l);
    end
    apb(0, 1'b0, 8'h40, 32'h0);
    chk({35'h0, err}, 36'h1);
    chk({4'h0, rd}, 36'h0);
    $display("unmapped access done");
    // second reset in mid-run
    sys_rst <= 1'b1;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    apb(1, 1'b0, REG_CFG, 32'h0);
    chk({4'h0, rd}, {28'h0, CFG_RESET});
    acc(1, 8'hF0, OP_RDBK, 15'h0, 36'h0);
    chk(q, 36'h0);
    $display("reset test done");
    report_and_stop();
  end
  // watchdog well beyond the thousand or so cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    report_and_stop();
  end
endmodule : tb
